// [tsq_pkg.sv]
/*
  Shared constants and types of the trigger sequencer queue register bank.
  Assumes one clock domain and an APB master with 32-bit data.
*/
// Behaviour
// - Counter 0 limit register, sixteen bits.
// - Counter 1 limit register, sixteen bits.
// - All registers read-only while steps execute.
// - Adjust value summed by add command.
// - Control command copies literal low six bits.
// - Strobe output carries command low bit and option.
// - Five-bit queue pointer, upper bits read zero.
// - Sixteen slots, odd byte high, even low.
// - All bits read/write, reset to zero; here STATUS, CNT0 and CNT1 are read-only.
// - Counter jump: limit advances, else loop.
// - Add adjust into option-selected target.
// - Reserved commands and options do nothing.
package tsq_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int PTR_W = 5;
  localparam int QIDX_W = 4;
  localparam int QUE_DEPTH = 16;
  localparam int CHSEL_W = 6;
  localparam int STRB_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_C0LIM = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_C1LIM = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_ADJ = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_LIT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_QPTR = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_CNT0 = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_CNT1 = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_QUE_BASE = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_QUE_LAST = 12'h07C;

  // Reset values
  localparam logic [REG_W-1:0] RST_REG = 16'h0000;
  localparam logic [PTR_W-1:0] RST_PTR = 5'h00;

  // Field positions
  localparam int ODD_LSB = 8;
  localparam int EVEN_LSB = 0;
  localparam int STATUS_BUSY_BIT = 0;

  // Command codes, upper three bits where the low bit is payload
  localparam logic [3:0] CMD_CTRL = 4'h0;
  localparam logic [3:0] CMD_ADD = 4'h1;
  localparam logic [2:0] CMD_STRB = 3'h1;
  localparam logic [2:0] CMD_JMP = 3'h5;
  localparam logic [2:0] CMD_JMPC0 = 3'h6;
  localparam logic [2:0] CMD_JMPC1 = 3'h7;

  // Option codes
  localparam logic [3:0] ADD_OPT_T0LIM = 4'h0;
  localparam logic [3:0] ADD_OPT_T1LIM = 4'h1;
  localparam logic [3:0] ADD_OPT_SDLIM = 4'h2;
  localparam logic [3:0] ADD_OPT_C0LIM = 4'h3;
  localparam logic [3:0] ADD_OPT_C1LIM = 4'h4;
  localparam logic [3:0] ADD_OPT_LIT = 4'h5;
  localparam logic [3:0] CTRL_OPT_LIT = 4'hF;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] option;
  } tsq_step_t;

  typedef struct packed {
    logic valid;
    logic [STRB_W-1:0] value;
  } tsq_strobe_t;

  typedef struct packed {
    logic valid;
    logic [CHSEL_W-1:0] channel;
  } tsq_chsel_t;

  typedef struct packed {
    logic valid;
    logic [3:0] option;
    logic [REG_W-1:0] adjust;
  } tsq_ext_add_t;

  typedef enum logic {PH_IDLE, PH_ANSWER} tsq_phase_t;

endpackage

// [tsq_step_mem.sv]
/*
  Step queue storage: sixteen 16-bit slots, two step bytes each.
  Assumes writes are already qualified by the caller; both reads registered.
*/
`timescale 1ns/100ps
module tsq_step_mem (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Word write
  input wire logic we,
  input wire logic [tsq_pkg::QIDX_W-1:0] waddr,
  input wire logic [tsq_pkg::REG_W-1:0] wdata,
  input wire logic [1:0] wstrb,
  // Word read for software
  input wire logic [tsq_pkg::QIDX_W-1:0] a_addr,
  output logic [tsq_pkg::REG_W-1:0] a_rdata,
  // Byte read for the active step
  input wire logic [tsq_pkg::PTR_W-1:0] b_addr,
  output logic [7:0] b_rdata
);

  logic [tsq_pkg::REG_W-1:0] mem_r [tsq_pkg::QUE_DEPTH];
  logic [tsq_pkg::REG_W-1:0] b_word;

  assign b_word = mem_r[b_addr[tsq_pkg::PTR_W-1:1]];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < tsq_pkg::QUE_DEPTH; i++) begin
        mem_r[i] <= tsq_pkg::RST_REG;
      end
    end else if (we) begin
      if (wstrb[0]) begin
        mem_r[waddr][7:0] <= wdata[7:0];
      end
      if (wstrb[1]) begin
        mem_r[waddr][15:8] <= wdata[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      a_rdata <= tsq_pkg::RST_REG;
    end else begin
      a_rdata <= mem_r[a_addr];
    end
  end

  // Odd step in the high byte, even step in the low byte
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      b_rdata <= 8'h00;
    end else if (b_addr[0]) begin
      b_rdata <= b_word[tsq_pkg::ODD_LSB +: 8];
    end else begin
      b_rdata <= b_word[tsq_pkg::EVEN_LSB +: 8];
    end
  end

endmodule

// [tsq_loop_counter.sv]
/*
  One 16-bit loop counter compared against its limit.
  Assumes clear and inc are never both high; clear wins if they are.
*/
`timescale 1ns/100ps
module tsq_loop_counter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic inc,
  input wire logic [tsq_pkg::REG_W-1:0] limit,
  // State
  output logic [tsq_pkg::REG_W-1:0] count,
  output logic at_limit
);

  assign at_limit = (count == limit);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= tsq_pkg::RST_REG;
    end else if (clear) begin
      count <= tsq_pkg::RST_REG;
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

endmodule

// [tsq_regs.sv]
/*
  Trigger sequencer queue register bank with its APB slave and the
  register-side effects of pointer, counter, add, strobe and control steps.
  Assumes an execution engine on ref_clk that raises seq_busy while running
  and pulses step_exec once per completed step.
*/
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
module tsq_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tsq_pkg::ADDR_W-1:0] paddr,
  input wire logic [tsq_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [tsq_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Execution engine
  input wire logic seq_busy,
  input wire logic step_exec,
  output tsq_pkg::tsq_step_t step_cmd,
  output logic [tsq_pkg::PTR_W-1:0] queue_pointer,
  // Values for the engine
  output logic [tsq_pkg::REG_W-1:0] loop_count0_limit,
  output logic [tsq_pkg::REG_W-1:0] loop_count1_limit,
  output logic [tsq_pkg::REG_W-1:0] loop_counter0,
  output logic [tsq_pkg::REG_W-1:0] loop_counter1,
  output logic [tsq_pkg::REG_W-1:0] adjust_value,
  output logic [tsq_pkg::REG_W-1:0] channel_literal,
  // Step effects leaving the block
  output tsq_pkg::tsq_strobe_t strobe_out,
  output tsq_pkg::tsq_chsel_t conversion_channel_select,
  output tsq_pkg::tsq_ext_add_t ext_add
);

  tsq_pkg::tsq_phase_t phase_r;
  logic apb_fire;
  logic wr_ok;
  logic mapped;
  logic is_queue;
  logic [tsq_pkg::DATA_W-1:0] prdata_r;
  logic [tsq_pkg::DATA_W-1:0] rd_mux;
  logic [tsq_pkg::REG_W-1:0] que_rdata;
  logic [7:0] step_byte;
  logic [tsq_pkg::QIDX_W-1:0] que_idx;
  logic [tsq_pkg::PTR_W-1:0] ptr_nxt;
  logic [tsq_pkg::PTR_W-1:0] jump_target;
  logic exec_add;
  logic exec_jc0;
  logic exec_jc1;
  logic eq0;
  logic eq1;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] res;
    res = old;
    if (st[0]) begin
      res[7:0] = wd[7:0];
    end
    if (st[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // APB: setup, one wait cycle to register read data, then answer
  assign apb_fire = psel && penable && pready;
  assign pready = (phase_r == tsq_pkg::PH_ANSWER);
  assign pslverr = pready && !mapped;
  assign prdata = prdata_r;
  // Busy drops software writes without an error answer
  assign wr_ok = apb_fire && pwrite && mapped && !seq_busy;

  assign is_queue = (paddr >= tsq_pkg::OFF_QUE_BASE) &&
                    (paddr <= tsq_pkg::OFF_QUE_LAST) &&
                    (paddr[1:0] == 2'b00);
  assign que_idx = paddr[5:2];

  always_comb begin
    mapped = 1'b1;
    if (!is_queue) begin
      case (paddr)
        tsq_pkg::OFF_C0LIM,
        tsq_pkg::OFF_C1LIM,
        tsq_pkg::OFF_ADJ,
        tsq_pkg::OFF_LIT,
        tsq_pkg::OFF_QPTR,
        tsq_pkg::OFF_STATUS,
        tsq_pkg::OFF_CNT0,
        tsq_pkg::OFF_CNT1: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_r <= tsq_pkg::PH_IDLE;
    end else begin
      case (phase_r)
        tsq_pkg::PH_IDLE: begin
          if (psel && penable) begin
            phase_r <= tsq_pkg::PH_ANSWER;
          end
        end
        tsq_pkg::PH_ANSWER: begin
          phase_r <= tsq_pkg::PH_IDLE;
        end
        default: phase_r <= tsq_pkg::PH_IDLE;
      endcase
    end
  end

  // Unused bits and unmapped addresses read as zero
  always_comb begin
    rd_mux = '0;
    if (is_queue) begin
      rd_mux[15:0] = que_rdata;
    end else begin
      case (paddr)
        tsq_pkg::OFF_C0LIM: rd_mux[15:0] = loop_count0_limit;
        tsq_pkg::OFF_C1LIM: rd_mux[15:0] = loop_count1_limit;
        tsq_pkg::OFF_ADJ: rd_mux[15:0] = adjust_value;
        tsq_pkg::OFF_LIT: rd_mux[15:0] = channel_literal;
        tsq_pkg::OFF_QPTR: rd_mux[tsq_pkg::PTR_W-1:0] = queue_pointer;
        tsq_pkg::OFF_STATUS: rd_mux[tsq_pkg::STATUS_BUSY_BIT] = seq_busy;
        tsq_pkg::OFF_CNT0: rd_mux[15:0] = loop_counter0;
        tsq_pkg::OFF_CNT1: rd_mux[15:0] = loop_counter1;
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_r <= '0;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  // Step decode
  assign step_cmd = tsq_pkg::tsq_step_t'(step_byte);
  assign jump_target = {step_cmd.cmd[0], step_cmd.option};
  assign exec_add = step_exec && (step_cmd.cmd == tsq_pkg::CMD_ADD);
  assign exec_jc0 = step_exec && (step_cmd.cmd[3:1] == tsq_pkg::CMD_JMPC0);
  assign exec_jc1 = step_exec && (step_cmd.cmd[3:1] == tsq_pkg::CMD_JMPC1);

  // Software write has priority; it is only possible while idle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      loop_count0_limit <= tsq_pkg::RST_REG;
    end else if (wr_ok && !is_queue && paddr == tsq_pkg::OFF_C0LIM) begin
      loop_count0_limit <= merge16(loop_count0_limit, pwdata, pstrb);
    end else if (exec_add && step_cmd.option == tsq_pkg::ADD_OPT_C0LIM) begin
      loop_count0_limit <= loop_count0_limit + adjust_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      loop_count1_limit <= tsq_pkg::RST_REG;
    end else if (wr_ok && !is_queue && paddr == tsq_pkg::OFF_C1LIM) begin
      loop_count1_limit <= merge16(loop_count1_limit, pwdata, pstrb);
    end else if (exec_add && step_cmd.option == tsq_pkg::ADD_OPT_C1LIM) begin
      loop_count1_limit <= loop_count1_limit + adjust_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      adjust_value <= tsq_pkg::RST_REG;
    end else if (wr_ok && !is_queue && paddr == tsq_pkg::OFF_ADJ) begin
      adjust_value <= merge16(adjust_value, pwdata, pstrb);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      channel_literal <= tsq_pkg::RST_REG;
    end else if (wr_ok && !is_queue && paddr == tsq_pkg::OFF_LIT) begin
      channel_literal <= merge16(channel_literal, pwdata, pstrb);
    end else if (exec_add && step_cmd.option == tsq_pkg::ADD_OPT_LIT) begin
      channel_literal <= channel_literal + adjust_value;
    end
  end

  // Pointer: jumps load, counted jumps loop, all else advance
  always_comb begin
    ptr_nxt = queue_pointer + 5'h01;
    case (step_cmd.cmd[3:1])
      tsq_pkg::CMD_JMP: ptr_nxt = jump_target;
      tsq_pkg::CMD_JMPC0: begin
        if (!eq0) begin
          ptr_nxt = jump_target;
        end
      end
      tsq_pkg::CMD_JMPC1: begin
        if (!eq1) begin
          ptr_nxt = jump_target;
        end
      end
      // Reserved and unhandled codes only step on
      default: ptr_nxt = queue_pointer + 5'h01;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      queue_pointer <= tsq_pkg::RST_PTR;
    end else if (wr_ok && !is_queue && paddr == tsq_pkg::OFF_QPTR) begin
      if (pstrb[0]) begin
        queue_pointer <= pwdata[tsq_pkg::PTR_W-1:0];
      end
    end else if (step_exec) begin
      queue_pointer <= ptr_nxt;
    end
  end

  // Counters restart when the engine stops or a loop completes
  tsq_loop_counter u_cnt0 (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(!seq_busy || (exec_jc0 && eq0)),
    .inc(exec_jc0 && !eq0),
    .limit(loop_count0_limit),
    .count(loop_counter0),
    .at_limit(eq0)
  );

  tsq_loop_counter u_cnt1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(!seq_busy || (exec_jc1 && eq1)),
    .inc(exec_jc1 && !eq1),
    .limit(loop_count1_limit),
    .count(loop_counter1),
    .at_limit(eq1)
  );

  tsq_step_mem u_mem (
    .ref_clk(ref_clk),
    .reset(reset),
    .we(wr_ok && is_queue),
    .waddr(que_idx),
    .wdata(pwdata[15:0]),
    .wstrb(pstrb[1:0]),
    .a_addr(que_idx),
    .a_rdata(que_rdata),
    .b_addr(queue_pointer),
    .b_rdata(step_byte)
  );

  // Strobe carries the command's low bit and option
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strobe_out <= '0;
    end else begin
      strobe_out.valid <= step_exec &&
                          (step_cmd.cmd[3:1] == tsq_pkg::CMD_STRB);
      if (step_exec && step_cmd.cmd[3:1] == tsq_pkg::CMD_STRB) begin
        strobe_out.value <= jump_target;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conversion_channel_select <= '0;
    end else begin
      conversion_channel_select.valid <= step_exec &&
        (step_cmd.cmd == tsq_pkg::CMD_CTRL) &&
        (step_cmd.option == tsq_pkg::CTRL_OPT_LIT);
      if (step_exec && step_cmd.cmd == tsq_pkg::CMD_CTRL &&
          step_cmd.option == tsq_pkg::CTRL_OPT_LIT) begin
        conversion_channel_select.channel <=
          channel_literal[tsq_pkg::CHSEL_W-1:0];
      end
    end
  end

  // Timer and step delay limits live outside; hand them the sum request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_add <= '0;
    end else begin
      ext_add.valid <= exec_add &&
        (step_cmd.option <= tsq_pkg::ADD_OPT_SDLIM);
      ext_add.option <= step_cmd.option;
      ext_add.adjust <= adjust_value;
    end
  end

endmodule

// [tsq_regs_sva.sv]
/*
  Checker for the sequencer queue register bank, bound to tsq_regs.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module tsq_regs_sva (
  // Clock, reset and APB
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tsq_pkg::ADDR_W-1:0] paddr,
  input wire logic [tsq_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Engine side
  input wire logic seq_busy,
  input wire logic step_exec,
  input wire tsq_pkg::tsq_step_t step_cmd,
  input wire logic [tsq_pkg::PTR_W-1:0] queue_pointer,
  input wire logic [tsq_pkg::REG_W-1:0] loop_count0_limit,
  input wire logic [tsq_pkg::REG_W-1:0] loop_counter0,
  input wire logic [tsq_pkg::REG_W-1:0] adjust_value,
  input wire logic [tsq_pkg::REG_W-1:0] channel_literal,
  input wire tsq_pkg::tsq_strobe_t strobe_out,
  input wire tsq_pkg::tsq_chsel_t conversion_channel_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  chk_apb_one_wait: assert property (s_setup |=> s_answer)
    else $error("APB answer not after one wait state");
  // Registers up to the pointer never answer with an error while busy
  chk_busy_no_error: assert property (pready && seq_busy &&
    paddr <= tsq_pkg::OFF_QPTR && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("Error answer for a mapped register while busy");
  chk_read_upper_zero: assert property (pready && !pwrite |->
    prdata[31:16] == 16'h0000)
    else $error("Read data upper half not zero");
  chk_ptr_read_zero: assert property (pready && !pwrite &&
    paddr == tsq_pkg::OFF_QPTR |-> prdata[15:5] == 11'h000)
    else $error("Pointer read shows unimplemented bits");
  // Only step effects may move registers while running
  chk_busy_hold: assert property (seq_busy && !step_exec |=>
    $stable(loop_count0_limit) && $stable(channel_literal) &&
    $stable(adjust_value) && $stable(queue_pointer))
    else $error("Register changed while steps execute");
  // Counters are held clear while idle, so only judge loops while busy
  chk_jc0_loop: assert property (seq_busy && step_exec &&
    step_cmd.cmd[3:1] == tsq_pkg::CMD_JMPC0 &&
    loop_counter0 != loop_count0_limit |=>
    queue_pointer == {$past(step_cmd.cmd[0]), $past(step_cmd.option)} &&
    loop_counter0 == $past(loop_counter0) + 16'h0001)
    else $error("Counter jump did not loop");
  chk_jc0_exit: assert property (step_exec &&
    step_cmd.cmd[3:1] == tsq_pkg::CMD_JMPC0 &&
    loop_counter0 == loop_count0_limit |=>
    queue_pointer == $past(queue_pointer) + 5'h01)
    else $error("Counter jump did not advance at limit");
  chk_add_literal: assert property (step_exec &&
    step_cmd == 8'h15 |=>
    channel_literal == $past(channel_literal) + $past(adjust_value))
    else $error("Add into literal wrong");
  chk_chsel_copy: assert property (step_exec &&
    step_cmd == 8'h0F |=> conversion_channel_select.valid &&
    conversion_channel_select.channel == $past(channel_literal[5:0]))
    else $error("Channel select not the literal");
  chk_strobe_copy: assert property (step_exec &&
    step_cmd.cmd[3:1] == tsq_pkg::CMD_STRB |=> strobe_out.valid &&
    strobe_out.value == {$past(step_cmd.cmd[0]), $past(step_cmd.option)})
    else $error("Strobe value wrong");
  chk_reserved_nop: assert property (step_exec &&
    step_cmd.cmd == 4'h6 |=>
    queue_pointer == $past(queue_pointer) + 5'h01 &&
    $stable(channel_literal) && !strobe_out.valid)
    else $error("Reserved step had an effect");
endmodule

// [testbench.sv]
/*
  Self-checking bench for tsq_regs: APB register access and a short
  step program. The bench itself plays the execution engine.
*/
`timescale 1ns/100ps
module testbench;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic seq_busy, step_exec;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  tsq_pkg::tsq_step_t step_cmd;
  logic [4:0] queue_pointer;
  logic [15:0] loop_count0_limit, loop_count1_limit, loop_counter0;
  logic [15:0] loop_counter1, adjust_value, channel_literal;
  tsq_pkg::tsq_strobe_t strobe_out;
  tsq_pkg::tsq_chsel_t conversion_channel_select;
  tsq_pkg::tsq_ext_add_t ext_add;
  int err_total = 0;
  int check_count = 0;

  tsq_regs i_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .seq_busy, .step_exec,
    .step_cmd, .queue_pointer, .loop_count0_limit, .loop_count1_limit,
    .loop_counter0, .loop_counter1, .adjust_value, .channel_literal,
    .strobe_out, .conversion_channel_select, .ext_add);

  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Leaves read data and error flag in rd and er
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1, "no APB answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs;
    logic [11:0] a [5];
    logic [11:0] q;
    logic [31:0] e;
    a = '{tsq_pkg::OFF_C0LIM, tsq_pkg::OFF_C1LIM, tsq_pkg::OFF_ADJ,
          tsq_pkg::OFF_LIT, tsq_pkg::OFF_QPTR};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0, 4'hF);
      chk(rd, 32'h0, "reset value");
      apb(1'b1, a[i], 32'hFFFF_5AA0 + 32'(i), 4'hF);
      apb(1'b0, a[i], 32'h0, 4'hF);
      e = (i == 4) ? 32'h0000_0004 : 32'h0000_5AA0 + 32'(i);
      chk(rd, e, "write readback");
    end
    // Low byte lane only
    apb(1'b1, tsq_pkg::OFF_C1LIM, 32'h0000_00C3, 4'h1);
    apb(1'b0, tsq_pkg::OFF_C1LIM, 32'h0, 4'hF);
    chk(rd, 32'h0000_5AC3, "byte lane write");
    for (int n = 0; n < 16; n++) begin
      q = tsq_pkg::OFF_QUE_BASE + 12'(4 * n);
      apb(1'b0, q, 32'h0, 4'hF);
      chk(rd, 32'h0, "queue reset");
      apb(1'b1, q, {16'h0, 8'(2 * n + 1), 8'(2 * n)}, 4'hF);
      apb(1'b0, q, 32'h0, 4'hF);
      chk(rd, {16'h0, 8'(2 * n + 1), 8'(2 * n)}, "queue slot");
    end
    apb(1'b1, 12'h020, 32'h1234, 4'hF);
    chk(er, 1'b1, "unmapped write");
    apb(1'b0, 12'h020, 32'h0, 4'hF);
    chk(rd, 32'h0, "unmapped read");
    chk(er, 1'b1, "unmapped error");
  endtask

  task automatic t_engine;
    logic [4:0] pe [8];
    logic [15:0] ce [8];
    pe = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h04, 5'h04, 5'h05, 5'h06};
    ce = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h2, 16'h0, 16'h0};
    apb(1'b1, tsq_pkg::OFF_LIT, 32'h0003, 4'hF);
    apb(1'b1, tsq_pkg::OFF_ADJ, 32'h0021, 4'hF);
    apb(1'b1, tsq_pkg::OFF_C0LIM, 32'h0002, 4'hF);
    apb(1'b1, tsq_pkg::OFF_QPTR, 32'h0000, 4'hF);
    apb(1'b1, tsq_pkg::OFF_QUE_BASE, 32'h0F15, 4'hF);
    apb(1'b1, tsq_pkg::OFF_QUE_BASE + 12'h004, 32'h603A, 4'hF);
    apb(1'b1, tsq_pkg::OFF_QUE_BASE + 12'h008, 32'h13C4, 4'hF);
    seq_busy <= 1'b1;
    apb(1'b1, tsq_pkg::OFF_C0LIM, 32'hBEEF, 4'hF);
    chk(er, 1'b0, "busy write flagged");
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      step_exec <= 1'b1;
      @(posedge ref_clk);
      step_exec <= 1'b0;
      #1;
      if (i == 1) begin
        chk(conversion_channel_select, {1'b1, 6'h24}, "chsel");
      end
      if (i == 2) chk(strobe_out, {1'b1, 5'h1A}, "strobe");
      repeat (2) @(posedge ref_clk);
      chk(queue_pointer, pe[i], "pointer");
      chk(loop_counter0, ce[i], "counter 0");
    end
    chk(channel_literal, 16'h0024, "add to literal");
    seq_busy <= 1'b0;
    apb(1'b0, tsq_pkg::OFF_C0LIM, 32'h0, 4'hF);
    chk(rd, 32'h0000_0023, "limit after add");
  endtask

  // Counter 1 loop, outside add request, plain jump and pointer wrap
  task automatic t_jumps;
    logic [4:0] pe [6];
    logic [15:0] ce [6];
    pe = '{5'h07, 5'h06, 5'h07, 5'h08, 5'h1F, 5'h00};
    ce = '{16'h0, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0};
    apb(1'b1, tsq_pkg::OFF_C1LIM, 32'h0001, 4'hF);
    apb(1'b1, tsq_pkg::OFF_QPTR, 32'h0006, 4'hF);
    apb(1'b1, tsq_pkg::OFF_QUE_BASE + 12'h00C, 32'hE612, 4'hF);
    apb(1'b1, tsq_pkg::OFF_QUE_BASE + 12'h010, 32'h00BF, 4'hF);
    seq_busy <= 1'b1;
    apb(1'b0, tsq_pkg::OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h0000_0001, "status busy");
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      step_exec <= 1'b1;
      @(posedge ref_clk);
      step_exec <= 1'b0;
      #1;
      chk(ext_add.valid, i == 0 || i == 2, "add req");
      if (i == 0) begin
        chk(ext_add, {1'b1, 4'h2, 16'h0021}, "add fields");
      end
      repeat (2) @(posedge ref_clk);
      chk(queue_pointer, pe[i], "jump pointer");
      chk(loop_counter1, ce[i], "counter 1");
    end
    seq_busy <= 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Whole run is a few hundred cycles
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    seq_busy = 1'b0;
    step_exec = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_engine;
    t_jumps;
    report_and_stop;
  end
endmodule

bind tsq_regs tsq_regs_sva u_sva (.ref_clk, .reset, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .seq_busy, .step_exec,
  .step_cmd, .queue_pointer, .loop_count0_limit, .loop_counter0,
  .adjust_value, .channel_literal, .strobe_out,
  .conversion_channel_select);
